// *** hw/insn_decoder_defs.vh ***
// constants for the instruction word decoder: opcodes, fields, classes, flags, registers
// assumes a single clock and a plain register port; opcode values are local choices
//
// Functional notes
// - 24-bit word, 8-bit opcode selects type
// - two-word instructions span 48 bits
// - extension word has upper eight bits zero
// - lone extension word executes as nop
// - exactly three two-word instructions exist
// - one cycle; taken test or jump adds nop
// - taken branches, table ops, returns take 2-3 cycles
// - taken skip: 2 or 3 cycles by size
// - every two-word instruction takes two cycles
// - three-operand: base, moded source, moded destination
// - file ops: address plus accumulator destination select
// - bit select from 4-bit literal or register
// - file address spans 0000h to 1FFFh
// - unsigned ten literal: byte 0-255, word 0-1023
// - program address literal has bit zero clear
// - signed ten literal is two's complement
// - register selectors address sixteen registers
// - direct, indirect, post/pre modified, base offset modes
// - five flags, only specified ones updated
// - size byte, word, double; word by default
// - divide takes a direct register pair
// - add with carry adds carry, updates all flags
// - multi-bit shift updates only negative, zero
// - branch: plain/computed 2, conditional 1 or 2
`ifndef INSN_DECODER_DEFS_VH
`define INSN_DECODER_DEFS_VH

// ****************************************
// opcodes
// ****************************************
`define OPC_EXT 8'h00
`define OPC_GOTO2 8'h02
`define OPC_CALL2 8'h03
`define OPC_MOVD2 8'h04
`define OPC_RET 8'h05
`define OPC_RETI 8'h06
`define OPC_TABLE 8'h07
`define OPC_IJUMP 8'h08
`define OPC_BR_UNCOND 8'h37
`define OPC_BR_COMPUTED 8'h38
`define OPC_FILE_ADD 8'h60
`define OPC_FILE_ADC 8'h61
`define OPC_LIT_ADD 8'h62
`define OPC_SHIFT_ONE 8'h63
`define OPC_SHIFT_MULTI 8'h64
`define OPC_BIT_LIT 8'h65
`define OPC_BIT_REG 8'h66
`define OPC_DIVIDE 8'h67
`define OPC_SKIP_CLR 8'h70
`define HI_BR_COND 5'h06
`define HI_ALU3_ADD 4'h4
`define HI_ALU3_ADC 4'h5

// ****************************************
// classes, modes, sizes
// ****************************************
`define CL_NOP 4'h0
`define CL_ALU3 4'h1
`define CL_FILE 4'h2
`define CL_LIT 4'h3
`define CL_SHIFT 4'h4
`define CL_BIT 4'h5
`define CL_DIV 4'h6
`define CL_BRANCH 4'h7
`define CL_SKIP 4'h8
`define CL_CTRL 4'h9
`define CL_MOVD 4'ha
`define CL_ILLEGAL 4'hf
`define MODE_DIRECT 3'h0
`define MODE_LAST 3'h6
`define SIZE_WORD 2'h0
`define SIZE_BYTE 2'h1
`define SIZE_DOUBLE 2'h2

// ****************************************
// flags, cycles, registers
// ****************************************
`define FLAG_CARRY 0
`define FLAG_DIGIT 1
`define FLAG_NEG 2
`define FLAG_OVERFLOW 3
`define FLAG_ZERO 4
`define MASK_ALL 5'h1f
`define MASK_NZ 5'h14
`define MASK_SHIFT_ONE 5'h1d
`define EXTRA_RET 2'h2
`define EXTRA_JUMP 2'h1
`define REG_FLAGS 4'h0
`define REG_STATE 4'h1
`define REG_CLEAR 4'h2
`define REG_LAST 4'h3

`endif

// *** hw/insn_decoder.v ***
// instruction word decoder with cycle scheduling and status flag keeping
// assumes a fetch unit offering words with valid/ready, and a datapath returning flags
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "insn_decoder_defs.vh"

module insn_decoder (
	input wire i_ref_clk,
	input wire i_reset,
	input wire i_word_valid,
	input wire [23:0] i_word,
	input wire i_test_bit,
	input wire i_alu_valid,
	input wire [4:0] i_alu_flags,
	input wire [3:0] i_addr,
	input wire [15:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg o_fetch_ready,
	output reg o_issue,
	output reg o_nop_cycle,
	output reg o_illegal,
	output reg [3:0] o_op_class,
	output reg [7:0] o_opcode,
	output reg [3:0] o_base_sel,
	output reg [3:0] o_src_sel,
	output reg [2:0] o_src_mode,
	output reg [3:0] o_dst_sel,
	output reg [2:0] o_dst_mode,
	output reg [12:0] o_file_addr,
	output reg o_dest_is_acc,
	output reg [3:0] o_bit_sel,
	output reg o_bit_indirect,
	output reg [9:0] o_unsigned_literal_ten,
	output reg [15:0] o_slit,
	output reg [22:0] o_prog_addr,
	output reg o_pc_load,
	output reg [1:0] o_size,
	output reg [4:0] o_flag_mask,
	output reg o_carry_in,
	output reg [4:0] o_flags,
	output reg [15:0] o_rdata
);

// ****************************************
// state and storage
// ****************************************
localparam ST_DEC = 4'b0001; // expecting first word
localparam ST_EXT = 4'b0010; // expecting extension word
localparam ST_STALL = 4'b0100; // burning nop cycles
localparam ST_SKIP = 4'b1000; // discarding skipped words

reg [3:0] state; // one-hot state
reg [3:0] next_state; // next state
reg [1:0] stall_cnt; // nop cycles left
reg skip_more; // skipped word was two-word
reg [15:0] first_low; // low half of a two-word first word
reg [7:0] first_opc; // opcode of the two-word first word
reg sticky_zero; // last issue keeps zero sticky
reg illegal_seen; // sticky illegal opcode status

wire [7:0] opc = i_word[23:16]; // opcode field
wire accept = i_word_valid & o_fetch_ready; // word taken this edge

// ****************************************
// combinational decode of the offered word
// ****************************************
reg [3:0] d_class; // instruction class
reg d_two; // first word of a two-word instruction
reg [1:0] d_extra; // nop cycles after issue
reg [4:0] d_mask; // flags the instruction may update
reg d_jump; // program counter changes
reg d_adc; // carry enters the sum
reg cond_true; // conditional branch test
reg ext_ok; // extension word marker holds

// condition test from held flags
always @* begin
	case (opc[2:0])
		3'h0: cond_true = o_flags[`FLAG_CARRY];
		3'h1: cond_true = o_flags[`FLAG_NEG];
		3'h2: cond_true = o_flags[`FLAG_OVERFLOW];
		3'h3: cond_true = o_flags[`FLAG_ZERO];
		3'h4: cond_true = ~o_flags[`FLAG_CARRY];
		3'h5: cond_true = ~o_flags[`FLAG_ZERO];
		3'h6: cond_true = ~o_flags[`FLAG_NEG];
		default: cond_true = 1'b0;
	endcase
end

// class, length, cycles and flag mask by opcode
always @* begin
	d_class = `CL_ILLEGAL;
	d_two = 1'b0;
	d_extra = 2'h0;
	d_mask = 5'h00;
	d_jump = 1'b0;
	d_adc = 1'b0;
	ext_ok = (opc == 8'h00);
	if (opc[7:4] == `HI_ALU3_ADD || opc[7:4] == `HI_ALU3_ADC) begin
		// mode 7 is not a legal addressing form
		if (i_word[6:4] <= `MODE_LAST && i_word[13:11] <= `MODE_LAST) begin
			d_class = `CL_ALU3;
			d_mask = `MASK_ALL;
			d_adc = (opc[7:4] == `HI_ALU3_ADC);
		end
	end else if (opc[7:3] == `HI_BR_COND && opc[2:0] != 3'h7) begin
		d_class = `CL_BRANCH;
		d_jump = cond_true;
		d_extra = {1'b0, cond_true};
	end else begin
		case (opc)
			`OPC_EXT: d_class = `CL_NOP;
			`OPC_GOTO2, `OPC_CALL2: begin
				d_class = `CL_CTRL;
				d_two = 1'b1;
				d_jump = 1'b1;
			end
			`OPC_MOVD2: begin
				d_class = `CL_MOVD;
				d_two = 1'b1;
			end
			`OPC_RET, `OPC_RETI: begin
				d_class = `CL_CTRL;
				d_jump = 1'b1;
				d_extra = `EXTRA_RET;
			end
			`OPC_TABLE: begin
				d_class = `CL_CTRL;
				d_extra = `EXTRA_JUMP;
			end
			`OPC_IJUMP, `OPC_BR_UNCOND, `OPC_BR_COMPUTED: begin
				d_class = (opc == `OPC_IJUMP) ? `CL_CTRL : `CL_BRANCH;
				d_jump = 1'b1;
				d_extra = `EXTRA_JUMP;
			end
			`OPC_FILE_ADD, `OPC_FILE_ADC: begin
				d_class = `CL_FILE;
				d_mask = `MASK_ALL;
				d_adc = (opc == `OPC_FILE_ADC);
			end
			`OPC_LIT_ADD: begin
				d_class = `CL_LIT;
				d_mask = `MASK_ALL;
			end
			`OPC_SHIFT_ONE: begin
				d_class = `CL_SHIFT;
				d_mask = `MASK_SHIFT_ONE;
			end
			`OPC_SHIFT_MULTI: begin
				d_class = `CL_SHIFT;
				d_mask = `MASK_NZ;
			end
			`OPC_BIT_LIT, `OPC_BIT_REG: d_class = `CL_BIT;
			`OPC_DIVIDE: d_class = `CL_DIV;
			`OPC_SKIP_CLR: d_class = `CL_SKIP;
			default: d_class = `CL_ILLEGAL;
		endcase
	end
end

// ****************************************
// next state
// ****************************************
always @* begin
	next_state = state;
	case (state)
		ST_DEC: begin
			if (accept) begin
				if (d_two) begin
					next_state = ST_EXT;
				end else if (d_class == `CL_SKIP && !i_test_bit) begin
					next_state = ST_SKIP;
				end else if (d_extra != 2'h0) begin
					next_state = ST_STALL;
				end
			end
		end
		ST_EXT: begin
			if (accept) begin
				next_state = ST_DEC;
			end
		end
		ST_STALL: begin
			if (stall_cnt == 2'h1) begin
				next_state = ST_DEC;
			end
		end
		ST_SKIP: begin
			// a two-word victim costs one more discarded word
			if (accept && (skip_more || !d_two)) begin
				next_state = ST_DEC;
			end
		end
		default: next_state = ST_DEC;
	endcase
end

// ****************************************
// sequencing and operand fields
// ****************************************
always @(posedge i_ref_clk or posedge i_reset) begin
	if (i_reset) begin
		state <= ST_DEC;
		o_fetch_ready <= 1'b1;
		stall_cnt <= 2'h0;
		skip_more <= 1'b0;
		first_low <= 16'h0000;
		first_opc <= 8'h00;
		sticky_zero <= 1'b0;
		o_issue <= 1'b0;
		o_nop_cycle <= 1'b0;
		o_illegal <= 1'b0;
		o_op_class <= `CL_NOP;
		o_opcode <= 8'h00;
		o_base_sel <= 4'h0;
		o_src_sel <= 4'h0;
		o_src_mode <= `MODE_DIRECT;
		o_dst_sel <= 4'h0;
		o_dst_mode <= `MODE_DIRECT;
		o_file_addr <= 13'h0000;
		o_dest_is_acc <= 1'b0;
		o_bit_sel <= 4'h0;
		o_bit_indirect <= 1'b0;
		o_unsigned_literal_ten <= 10'h000;
		o_slit <= 16'h0000;
		o_prog_addr <= 23'h000000;
		o_pc_load <= 1'b0;
		o_size <= `SIZE_WORD;
		o_flag_mask <= 5'h00;
		o_carry_in <= 1'b0;
	end else begin
		state <= next_state;
		o_fetch_ready <= (next_state != ST_STALL);
		o_issue <= 1'b0;
		o_nop_cycle <= 1'b0;
		o_illegal <= 1'b0;
		o_pc_load <= 1'b0;
		// nop cycle count for stalls
		if (state == ST_STALL) begin
			o_nop_cycle <= 1'b1;
			stall_cnt <= stall_cnt - 2'h1;
		end else if (accept && state == ST_DEC) begin
			stall_cnt <= d_extra;
		end
		// discarded words are nop cycles
		if (state == ST_SKIP && accept) begin
			o_nop_cycle <= 1'b1;
			skip_more <= (!skip_more && d_two);
		end
		// first word of a two-word instruction: held until its extension
		if (state == ST_DEC && accept && d_two) begin
			first_low <= i_word[15:0];
			first_opc <= opc;
		end
		// single-word issue
		if (state == ST_DEC && accept && !d_two) begin
			o_issue <= 1'b1;
			o_illegal <= (d_class == `CL_ILLEGAL);
			o_op_class <= d_class;
			o_opcode <= opc;
			o_flag_mask <= d_mask;
			sticky_zero <= d_adc;
			o_carry_in <= d_adc & o_flags[`FLAG_CARRY];
			o_pc_load <= d_jump;
			// default word size; double reads as word here
			o_size <= (i_word[15:14] == `SIZE_BYTE) ? `SIZE_BYTE : `SIZE_WORD;
			o_base_sel <= (d_class == `CL_DIV) ? i_word[7:4] :
				(d_class == `CL_ALU3) ? opc[3:0] : i_word[15:12];
			o_src_sel <= i_word[3:0];
			o_src_mode <= (d_class == `CL_DIV) ? `MODE_DIRECT : i_word[6:4];
			o_dst_sel <= (d_class == `CL_LIT || opc == `OPC_SHIFT_MULTI) ?
				i_word[3:0] : i_word[10:7];
			o_dst_mode <= (d_class == `CL_ALU3 || opc == `OPC_SHIFT_ONE) ?
				i_word[13:11] : `MODE_DIRECT;
			o_file_addr <= i_word[12:0];
			o_dest_is_acc <= i_word[13];
			o_bit_sel <= i_word[15:12];
			o_bit_indirect <= (opc == `OPC_BIT_REG);
			// byte mode keeps only the low eight literal bits
			o_unsigned_literal_ten <= (i_word[15:14] == `SIZE_BYTE) ?
				{2'b00, i_word[11:4]} : i_word[13:4];
			o_slit <= {{6{i_word[9]}}, i_word[9:0]};
		end
		// extension word completes the two-word instruction
		if (state == ST_EXT && accept) begin
			o_issue <= 1'b1;
			o_illegal <= !ext_ok;
			o_op_class <= ext_ok ? ((first_opc == `OPC_MOVD2) ? `CL_MOVD : `CL_CTRL) :
				`CL_ILLEGAL;
			o_opcode <= first_opc;
			o_flag_mask <= 5'h00;
			sticky_zero <= 1'b0;
			o_carry_in <= 1'b0;
			o_pc_load <= ext_ok && (first_opc != `OPC_MOVD2);
			o_size <= (first_opc == `OPC_MOVD2) ? `SIZE_DOUBLE : `SIZE_WORD;
			o_prog_addr <= {i_word[6:0], first_low[15:1], 1'b0};
			o_file_addr <= first_low[12:0];
			o_dst_sel <= i_word[3:0];
			o_dst_mode <= `MODE_DIRECT;
		end
	end
end

// ****************************************
// status flags and sticky illegal status
// ****************************************
reg [4:0] next_flags; // flags after datapath update

// datapath update touches only masked flags
always @* begin
	next_flags = o_flags;
	if (i_wr && i_addr == `REG_FLAGS) begin
		next_flags = i_wdata[4:0];
	end
	if (i_alu_valid) begin
		// masked bits take the datapath value, the rest hold
		next_flags = (next_flags & ~o_flag_mask) | (i_alu_flags & o_flag_mask);
		// zero only clears across a carry chain
		if (o_flag_mask[`FLAG_ZERO] && sticky_zero) begin
			next_flags[`FLAG_ZERO] = o_flags[`FLAG_ZERO] & i_alu_flags[`FLAG_ZERO];
		end
	end
end

// flags register and illegal status, set beats clear
always @(posedge i_ref_clk or posedge i_reset) begin
	if (i_reset) begin
		o_flags <= 5'h00;
		illegal_seen <= 1'b0;
	end else begin
		o_flags <= next_flags;
		if (o_illegal) begin
			illegal_seen <= 1'b1;
		end else if (i_wr && i_addr == `REG_CLEAR && i_wdata[0]) begin
			illegal_seen <= 1'b0;
		end
	end
end

// ****************************************
// register read port
// ****************************************
// read data stands in the cycle after the strobe only
always @(posedge i_ref_clk or posedge i_reset) begin
	if (i_reset) begin
		o_rdata <= 16'h0000;
	end else if (i_rd) begin
		case (i_addr)
			`REG_FLAGS: o_rdata <= {11'h000, o_flags};
			`REG_STATE: o_rdata <= {9'h000, illegal_seen, skip_more, 1'b0, state};
			`REG_LAST: o_rdata <= {4'h0, o_op_class, o_opcode};
			default: o_rdata <= 16'h0000;
		endcase
	end else begin
		o_rdata <= 16'h0000;
	end
end

endmodule

// *** tb/insn_decoder_props.sv ***
// checker: word pairing, skips and cycle counts of the decoder
// assumes a bind to insn_decoder, one clock, async active-high reset
`timescale 1ns/10ps
`include "insn_decoder_defs.vh"
module insn_decoder_props (
	input wire i_ref_clk,
	input wire i_reset,
	input wire i_word_valid,
	input wire [23:0] i_word,
	input wire i_test_bit,
	input wire o_fetch_ready,
	input wire o_issue,
	input wire o_nop_cycle,
	input wire o_illegal,
	input wire [3:0] o_op_class,
	input wire [22:0] o_prog_addr,
	input wire o_pc_load
);
	// ****
	// word tracking
	// ****
	reg second; // next word is an extension
	reg skip; // next word is thrown away
	reg [23:0] first; // first half of a pair
	wire take = i_word_valid & o_fetch_ready;
	wire [7:0] opc = i_word[23:16];
	wire [6:0] ext_lo = i_word[6:0];
	wire two = opc == `OPC_GOTO2 || opc == `OPC_CALL2 || opc == `OPC_MOVD2;
	wire fresh = take & ~second & ~skip;
	wire ext = take & second & ~skip;
	// follow pairs and pending skips
	always @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			second <= 1'b0;
			skip <= 1'b0;
			first <= 24'h000000;
		end else if (take) begin
			second <= ~second & two;
			skip <= (fresh & opc == `OPC_SKIP_CLR & ~i_test_bit) | (skip & ~second & two);
			if (~second) begin
				first <= i_word;
			end
		end
	end
	// ****
	// properties
	// ****
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_reset);
	property p_single;
		fresh && opc == `OPC_FILE_ADD |=> o_issue && o_op_class == `CL_FILE;
	endproperty
	a_single: assert property (p_single) else $error("file op not issued");
	property p_first;
		fresh && two |=> !o_issue;
	endproperty
	a_first: assert property (p_first) else $error("first half issued");
	property p_pair;
		ext && opc == `OPC_EXT |=> o_issue && !o_illegal
			&& o_prog_addr == {$past(ext_lo), first[15:1], 1'b0};
	endproperty
	a_pair: assert property (p_pair) else $error("pair address wrong");
	property p_bad_ext;
		ext && opc != `OPC_EXT |=> o_issue && o_illegal;
	endproperty
	a_bad_ext: assert property (p_bad_ext) else $error("bad extension passed");
	property p_lone;
		fresh && opc == `OPC_EXT |=> o_issue && o_op_class == `CL_NOP && !o_pc_load;
	endproperty
	a_lone: assert property (p_lone) else $error("lone extension not nop");
	property p_branch;
		fresh && (opc == `OPC_BR_UNCOND || opc == `OPC_BR_COMPUTED)
			|=> o_issue && o_pc_load && !o_fetch_ready ##1 o_nop_cycle && o_fetch_ready;
	endproperty
	a_branch: assert property (p_branch) else $error("branch timing");
	property p_return;
		fresh && (opc == `OPC_RET || opc == `OPC_RETI) |=> o_issue && !o_fetch_ready
			##1 o_nop_cycle && !o_fetch_ready ##1 o_nop_cycle && o_fetch_ready;
	endproperty
	a_return: assert property (p_return) else $error("return timing");
	property p_drop;
		take && skip |=> o_nop_cycle && !o_issue;
	endproperty
	a_drop: assert property (p_drop) else $error("skipped word issued");
	c_pair: cover property (ext && opc == `OPC_EXT);
	c_drop: cover property (take && skip);
	c_bad: cover property (o_issue && o_illegal);
endmodule
bind insn_decoder insn_decoder_props u_insn_decoder_props (
	.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_word_valid(i_word_valid),
	.i_word(i_word), .i_test_bit(i_test_bit), .o_fetch_ready(o_fetch_ready),
	.o_issue(o_issue), .o_nop_cycle(o_nop_cycle), .o_illegal(o_illegal),
	.o_op_class(o_op_class), .o_prog_addr(o_prog_addr), .o_pc_load(o_pc_load)
);

// *** tb/fetch_model.sv ***
// fetch unit and datapath stand-in: offers queued words, answers issues with flags
// assumes the decoder's valid/ready fetch and its one-cycle issue pulse
`timescale 1ns/10ps
module fetch_model (
	input wire i_ref_clk,
	input wire i_reset,
	input wire i_ready,
	input wire i_issue,
	output reg o_valid,
	output reg [23:0] o_word,
	output reg o_test_bit,
	output reg o_alu_valid,
	output reg [4:0] o_alu_flags
);
	reg [24:0] q[$]; // queued {test bit, word}
	reg alu_on = 1'b0; // datapath answers when set
	reg [4:0] alu_ret = 5'h00; // flags handed back
	// word stays put until taken; idle lines toggle
	always @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			o_valid <= 1'b0;
			o_word <= 24'hffffff;
			o_test_bit <= 1'b0;
			o_alu_valid <= 1'b0;
			o_alu_flags <= 5'h00;
		end else begin
			o_alu_valid <= alu_on & i_issue;
			o_alu_flags <= (alu_on & i_issue) ? alu_ret : ~o_alu_flags;
			if (!o_valid || i_ready) begin
				if (q.size() != 0) begin
					o_valid <= 1'b1;
					{o_test_bit, o_word} <= q.pop_front();
				end else begin
					o_valid <= 1'b0;
					o_word <= ~o_word;
				end
			end
		end
	end
endmodule

// *** tb/cpu_instruction_format_decoder_tb.sv ***
// bench for the decoder: fields, pairs, cycle counts, skips, flags, registers
// assumes fetch_model on the fetch side, 4 ns clock
`timescale 1ns/10ps
`include "insn_decoder_defs.vh"
module cpu_instruction_format_decoder_tb;
	reg i_ref_clk = 1'b0;
	reg i_reset = 1'b1;
	reg [3:0] i_addr = 4'h0;
	reg [15:0] i_wdata = 16'h0000;
	reg i_wr = 1'b0;
	reg i_rd = 1'b0;
	wire i_word_valid, i_test_bit, i_alu_valid, o_fetch_ready, o_issue, o_nop_cycle;
	wire o_illegal, o_dest_is_acc, o_bit_indirect, o_pc_load, o_carry_in;
	wire [23:0] i_word;
	wire [4:0] i_alu_flags, o_flag_mask, o_flags;
	wire [3:0] o_op_class, o_base_sel, o_src_sel, o_dst_sel, o_bit_sel;
	wire [2:0] o_src_mode, o_dst_mode;
	wire [7:0] o_opcode;
	wire [12:0] o_file_addr;
	wire [9:0] o_unsigned_literal_ten;
	wire [22:0] o_prog_addr;
	wire [1:0] o_size;
	wire [15:0] o_rdata, o_slit;
	integer miscompares = 0;
	integer comparisons = 0;
	integer cyc = 0;
	// ****
	// clock and parts
	// ****
	always #2 i_ref_clk = ~i_ref_clk;
	insn_decoder u_insn_decoder (
		.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_word_valid(i_word_valid),
		.i_word(i_word), .i_test_bit(i_test_bit), .i_alu_valid(i_alu_valid),
		.i_alu_flags(i_alu_flags), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_fetch_ready(o_fetch_ready), .o_issue(o_issue),
		.o_nop_cycle(o_nop_cycle), .o_illegal(o_illegal), .o_op_class(o_op_class),
		.o_opcode(o_opcode), .o_base_sel(o_base_sel), .o_src_sel(o_src_sel),
		.o_src_mode(o_src_mode), .o_dst_sel(o_dst_sel), .o_dst_mode(o_dst_mode),
		.o_file_addr(o_file_addr), .o_dest_is_acc(o_dest_is_acc), .o_bit_sel(o_bit_sel),
		.o_bit_indirect(o_bit_indirect), .o_unsigned_literal_ten(o_unsigned_literal_ten), .o_slit(o_slit),
		.o_prog_addr(o_prog_addr), .o_pc_load(o_pc_load), .o_size(o_size),
		.o_flag_mask(o_flag_mask), .o_carry_in(o_carry_in), .o_flags(o_flags),
		.o_rdata(o_rdata)
	);
	fetch_model u_fetch_model (
		.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_ready(o_fetch_ready),
		.i_issue(o_issue), .o_valid(i_word_valid), .o_word(i_word),
		.o_test_bit(i_test_bit), .o_alu_valid(i_alu_valid), .o_alu_flags(i_alu_flags)
	);
	// ****
	// helpers
	// ****
	task check(input [31:0] seen, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
			if (miscompares == 0 && comparisons > 0) begin
				$display("Run complete: PASS");
			end else begin
				$display("Run complete: FAIL");
			end
			$finish;
		end
	endtask
	task push(input [23:0] w, input t);
		u_fetch_model.q.push_back({t, w});
	endtask
	// cycles waited until the next issue pulse
	task wait_iss(output integer n);
		begin
			n = 0;
			@(negedge i_ref_clk);
			while (o_issue !== 1'b1 && n < 40) begin
				n = n + 1;
				@(negedge i_ref_clk);
			end
			if (n == 40) begin
				miscompares = miscompares + 1;
			end
		end
	endtask
	task one(input [23:0] w);
		integer n;
		begin
			push(w, 1'b0);
			wait_iss(n);
		end
	endtask
	task wr(input [3:0] a, input [15:0] d);
		begin
			@(posedge i_ref_clk);
			i_addr <= a;
			i_wdata <= d;
			i_wr <= 1'b1;
			@(posedge i_ref_clk);
			i_wr <= 1'b0;
		end
	endtask
	task rd(input [3:0] a, output [15:0] v);
		begin
			@(posedge i_ref_clk);
			i_addr <= a;
			i_rd <= 1'b1;
			@(posedge i_ref_clk);
			i_rd <= 1'b0;
			@(negedge i_ref_clk);
			v = o_rdata;
		end
	endtask
	// issue-to-issue gap of an op followed by a file op
	task gap_of(input [7:0] op, input [3:0] exp);
		integer n;
		begin
			push({op, 16'h0000}, 1'b1);
			push(24'h603000, 1'b0);
			wait_iss(n);
			wait_iss(n);
			check(n + 1, exp);
		end
	endtask
	task flag_step(input [23:0] w, input [4:0] ret, input [4:0] exp);
		reg [15:0] v;
		begin
			u_fetch_model.alu_ret = ret;
			one(w);
			repeat (3) @(negedge i_ref_clk);
			rd(`REG_FLAGS, v);
			check(v[4:0], exp);
		end
	endtask
	// ****
	// scenarios
	// ****
	task t_fields;
		begin
			one(24'h4414ef);
			check(o_base_sel, 4'h4);
			check({o_dst_mode, o_dst_sel}, {3'h2, 4'h9});
			check({o_src_mode, o_src_sel}, {3'h6, 4'hf});
			check(o_size, `SIZE_WORD);
			check(o_slit, 16'h00ef);
			one(24'h603fff);
			check({o_dest_is_acc, o_file_addr}, 14'h3fff);
			one(24'h624ff3);
			check({o_size, o_unsigned_literal_ten}, {`SIZE_BYTE, 10'h0ff});
			check(o_slit, 16'hfff3);
			one(24'h623ff5);
			check(o_unsigned_literal_ten, 10'h3ff);
			one(24'h65f003);
			check({o_bit_indirect, o_bit_sel}, 5'h0f);
			one(24'h66a003);
			check({o_bit_indirect, o_base_sel}, 5'h1a);
			one(24'h6700a5);
			check({o_base_sel, o_src_sel, o_src_mode}, {4'ha, 4'h5, `MODE_DIRECT});
			one(24'h4400f0);
			check({o_illegal, o_op_class}, {1'b1, `CL_ILLEGAL});
		end
	endtask
	task t_two;
		integer n;
		reg [15:0] v;
		begin
			push(24'h603000, 1'b0);
			push(24'h02abcd, 1'b0);
			push(24'h00007f, 1'b0);
			wait_iss(n);
			wait_iss(n);
			check(n + 1, 2);
			check(o_prog_addr, {7'h7f, 15'h55e6, 1'b0});
			check(o_pc_load, 1'b1);
			push(24'h03abcd, 1'b0);
			one(24'h000001);
			check({o_op_class, o_pc_load, o_prog_addr}, {`CL_CTRL, 1'b1, 7'h01, 15'h55e6, 1'b0});
			push(24'h04abcd, 1'b0);
			one(24'h000001);
			check({o_op_class, o_size, o_pc_load}, {`CL_MOVD, `SIZE_DOUBLE, 1'b0});
			one(24'h001234);
			check({o_illegal, o_op_class}, {1'b0, `CL_NOP});
			push(24'h02abcd, 1'b0);
			one(24'h550000);
			check(o_illegal, 1'b1);
			one(24'hff0000);
			check({o_illegal, o_op_class}, {1'b1, `CL_ILLEGAL});
			rd(`REG_STATE, v);
			check(v[6], 1'b1);
			wr(`REG_CLEAR, 16'h0001);
			rd(`REG_STATE, v);
			check(v[6], 1'b0);
			rd(4'h7, v);
			check(v, 16'h0000);
		end
	endtask
	task t_cycles;
		begin
			gap_of(`OPC_FILE_ADD, 4'h1);
			gap_of(`OPC_BR_UNCOND, 4'h2);
			gap_of(`OPC_BR_COMPUTED, 4'h2);
			gap_of(`OPC_RET, 4'h3);
			gap_of(`OPC_RETI, 4'h3);
			gap_of(`OPC_TABLE, 4'h2);
			gap_of(`OPC_IJUMP, 4'h2);
			wr(`REG_FLAGS, 16'h0000);
			gap_of(8'h30, 4'h1);
			wr(`REG_FLAGS, 16'h0001);
			gap_of(8'h30, 4'h2);
			gap_of(8'h34, 4'h1);
		end
	endtask
	task t_skip;
		integer n;
		begin
			push(24'h700000, 1'b0);
			push(24'h02abcd, 1'b0);
			push(24'h00007f, 1'b0);
			push(24'h603000, 1'b0);
			push(24'h700000, 1'b0);
			push(24'h624ff3, 1'b0);
			push(24'h700000, 1'b1);
			push(24'h623ff5, 1'b0);
			wait_iss(n);
			wait_iss(n);
			check(n + 1, 3);
			wait_iss(n);
			wait_iss(n);
			check(n + 1, 2);
			wait_iss(n);
			check({o_opcode, n[7:0]}, 16'h6200);
		end
	endtask
	task t_flags;
		begin
			wr(`REG_FLAGS, 16'h001f);
			u_fetch_model.alu_on = 1'b1;
			flag_step(24'h640000, 5'h00, 5'h0b);
			check(o_flag_mask, 5'h14);
			flag_step(24'h603000, 5'h15, 5'h15);
			flag_step(24'h613000, 5'h0b, 5'h0b);
			check(o_carry_in, 1'b1);
			flag_step(24'h613000, 5'h1f, 5'h0f);
			flag_step(24'h630000, 5'h00, 5'h02);
			check(o_flags, 5'h02);
			u_fetch_model.alu_on = 1'b0;
		end
	endtask
	// ****
	// main sequence and hang limit
	// ****
	initial begin : main
		reg [15:0] v;
		repeat (8) @(posedge i_ref_clk);
		i_reset <= 1'b0;
		rd(`REG_FLAGS, v);
		check(v, 16'h0000);
		t_fields;
		t_two;
		t_cycles;
		t_skip;
		t_flags;
		report_and_stop;
	end
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares = miscompares + 1;
			report_and_stop;
		end
	end
endmodule
